// file: src/swc_pkg.sv
// sleep/wake controller package: register map, fields, timing
package swc_pkg;
    // byte addresses: offsets printed are not all multiples of four, so addr = 4 * index
    localparam logic [15:0] CORE_STATUS_IDX = 16'h0003;
    localparam logic [15:0] WATCHDOG_CONTROL_IDX = 16'h0018;
    localparam logic [15:0] TIMER_PRESCALE_OPTIONS_IDX = 16'h0081;
    localparam logic [15:0] DEVICE_CONFIG_WORD_IDX = 16'h2007;
    localparam logic [15:0] SLEEP_CTRL_IDX = 16'h0100;
    localparam logic [15:0] IRQ_ENABLE_IDX = 16'h0101;
    localparam logic [15:0] IRQ_FLAG_IDX = 16'h0102;
    localparam logic [15:0] SLEEP_STATE_IDX = 16'h0103;

    localparam logic [7:0] WDOG_CTRL_RST = 8'h08;
    localparam logic [7:0] OPTIONS_RST = 8'hff;
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [7:0] WDOG_CTRL_MASK = 8'h1f;

    localparam int STATUS_TO_BIT = 4;
    localparam int STATUS_PD_BIT = 3;
    localparam int SOFT_WATCHDOG_ENABLE_BIT = 0;
    localparam int CFG_WATCHDOG_FUSE_ENABLE_BIT = 3;
    localparam int CFG_FOSC_LSB = 0;
    localparam int SLP_GIE_BIT = 0;
    localparam int SLP_PERIPHERAL_IRQ_GROUP_ENABLE_BIT = 1;
    localparam int SLP_SLEEP_BIT = 7;
    localparam int SLP_WATCHDOG_CLEAR_INSTR_BIT = 6;

    // irq sources: 0 ext pin, 1 on-change, 2..7 peripheral (need group enable)
    localparam int NUM_IRQ = 8;
    localparam int IRQ_CORE_CNT = 2;
    // mask of peripherals able to run asleep: tmr1 async, capture, adc rc,
    // eeprom, comparator; bit 2 timer2 needs clock so it cannot wake
    localparam logic [7:0] SLEEP_CAPABLE = 8'hfb;

    // oscillator modes needing start-up delay: lp, xt, hs
    localparam logic [2:0] FOSC_LP = 3'h0;
    localparam logic [2:0] FOSC_XT = 3'h1;
    localparam logic [2:0] FOSC_HS = 3'h2;

    localparam int OST_TOSC = 1024;
    localparam int OST_CYCLES = OST_TOSC;
    localparam int WDOG_W = 24;

    typedef enum logic [2:0] {
        SWC_RUN = 3'b000,
        SWC_ENTER = 3'b001,
        SWC_SLEEP = 3'b011,
        SWC_OST = 3'b010,
        SWC_RESUME = 3'b110
    } swc_state_e;

    typedef struct packed {
        logic timeout_flag_n;
        logic powerdown_flag_n;
    } swc_flags_s;
endpackage

// file: src/swc_sleep_wake.sv
// sleep/wake controller with watchdog and ahb-lite registers
// Contract
// (R1) sleep entered only by power-down instruction; code also enters on a write of sleep control bit 7
// (R2) sleep entry with watchdog on clears count, keeps it running
// (R3) sleep entry clears powerdown flag, sets timeout flag
// (R4) main oscillator off during sleep; watchdog base keeps running
// (R5) pin drive state held through sleep
// (R6) outside circuit keeps master clear high while asleep
// (R7) watchdog reset never drives master clear pin
// (R8) pin wake resets; watchdog or interrupt wake resumes
// (R9) powerdown flag set at power-up; timeout cleared by watchdog wake
// (R10) listed peripheral interrupts may wake from sleep
// (R11) clock-needing peripherals cannot raise wake in sleep
// (R12) next instruction prefetched while power-down executes
// (R13) wake needs own and group enable; global enable ignored; code needs the group enable only for sources 2..7
// (R14) global off: continue inline; on: prefetched then vector
// (R15) pending enabled source with global off wakes at once
// (R16) every wake clears watchdog count
// (R17) interrupt pending before instruction: acts as nop
// (R18) interrupt during instruction: complete, then wake with flags
// (R19) software reads powerdown flag to see if sleep happened
// (R20) software clears watchdog before sleep when globals off
// (R21) crystal modes wait start-up delay on wake
// (R22) fuse forces watchdog on; else software bit decides
// (R23) watchdog held cleared until start-up timer ends
// (R24) flags update synchronously at one clock edge
module swc_sleep_wake
    import swc_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RSTN_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    input wire logic SLEEP_INSTR_I,
    input wire logic WATCHDOG_CLEAR_INSTR_INSTR_I,
    input wire logic [NUM_IRQ-1:0] IRQ_FLAG_I,
    input wire logic [7:0] PIN_OUT_I,
    input wire logic [7:0] PIN_OE_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    output logic OSC_EN_O,
    output logic CORE_RUN_O,
    output logic PREFETCH_O,
    output logic VECTOR_JUMP_O,
    output logic WDOG_RESET_O,
    output logic MASTER_CLEAR_OE_O,
    output logic [7:0] PIN_OUT_O,
    output logic [7:0] PIN_OE_O
);
    swc_state_e state_r, state_nxt;
    swc_flags_s flags_r, flags_nxt;
    logic [7:0] wdog_ctrl_r;
    logic [7:0] options_r;
    logic [7:0] config_r;
    logic [7:0] slp_ctrl_r;
    logic [7:0] irq_en_r;
    logic [7:0] irq_flag_r;
    logic [WDOG_W-1:0] wdog_cnt_r;
    logic [10:0] ost_cnt_r;
    logic [7:0] pin_out_r, pin_oe_r;
    logic wr_pend_r;
    logic [15:0] wr_idx_r;
    logic [31:0] hrdata_r;
    logic osc_en_r, core_run_r, prefetch_r, vector_r, wdog_rst_r;

    function automatic logic [WDOG_W-1:0] wdog_limit(input logic [3:0] ps);
        logic [4:0] sh;
        sh = 5'(ps) + 5'h05;
        wdog_limit = (ps > 4'hb) ? {WDOG_W{1'b1}} : WDOG_W'((24'h1 << sh) - 24'h1);
    endfunction

    // crystal modes pass through the start-up timer on wake
    function automatic swc_state_e wake_state(input logic xtal);
        wake_state = xtal ? SWC_OST : SWC_RESUME;
    endfunction

    // bus decode
    wire [15:0] acc_idx = HADDR_I[17:2];
    wire bus_go = HSEL_I & HTRANS_I[1] & HREADY_I;
    wire bus_rd = bus_go & ~HWRITE_I;
    wire bus_wr = bus_go & HWRITE_I;
    wire wr_wdog = wr_pend_r & (wr_idx_r == WATCHDOG_CONTROL_IDX);
    wire wr_opt = wr_pend_r & (wr_idx_r == TIMER_PRESCALE_OPTIONS_IDX);
    wire wr_slp = wr_pend_r & (wr_idx_r == SLEEP_CTRL_IDX);
    wire wr_ien = wr_pend_r & (wr_idx_r == IRQ_ENABLE_IDX);
    wire wr_ifl = wr_pend_r & (wr_idx_r == IRQ_FLAG_IDX);
    wire [7:0] wd8 = HWDATA_I[7:0];

    // (R22) fuse or software enable
    wire wdog_on = config_r[CFG_WATCHDOG_FUSE_ENABLE_BIT] | wdog_ctrl_r[SOFT_WATCHDOG_ENABLE_BIT];
    wire [2:0] fosc = config_r[CFG_FOSC_LSB +: 3];
    // (R21) crystal modes only
    wire xtal_mode = (fosc == FOSC_LP) | (fosc == FOSC_XT) | (fosc == FOSC_HS);

    // (R13) own enable plus group enable for sources 2..7 (0 and 1 need own enable only), global ignored
    wire [NUM_IRQ-1:0] grp_ok = {{(NUM_IRQ-IRQ_CORE_CNT){slp_ctrl_r[SLP_PERIPHERAL_IRQ_GROUP_ENABLE_BIT]}},
                                 {IRQ_CORE_CNT{1'b1}}};
    wire [NUM_IRQ-1:0] armed = irq_en_r & irq_flag_r & grp_ok;
    // (R10) sleep-capable sources only, (R11) others gated off in sleep
    wire [NUM_IRQ-1:0] armed_sleep = armed & SLEEP_CAPABLE;
    wire irq_pend = |armed;
    wire irq_wake = |armed_sleep;
    wire sleep_req = SLEEP_INSTR_I | (wr_slp & wd8[SLP_SLEEP_BIT]);
    wire watchdog_clear_instr_req = WATCHDOG_CLEAR_INSTR_INSTR_I | (wr_slp & wd8[SLP_WATCHDOG_CLEAR_INSTR_BIT]);
    wire wdog_expire = wdog_on & (wdog_cnt_r >= wdog_limit(wdog_ctrl_r[4:1]));
    wire in_sleep = (state_r == SWC_SLEEP);

    // next state of the sleep sequencer
    always_comb begin
        state_nxt = state_r;
        flags_nxt = flags_r;
        case (state_r)
            SWC_RUN: begin
                // (R1) the power-down instruction or a write of sleep control bit 7 enters sleep
                if (sleep_req) begin
                    // (R17) pending source makes it a nop
                    if (!irq_pend) begin
                        // (R3) flags on entry
                        flags_nxt.powerdown_flag_n = 1'b0;
                        flags_nxt.timeout_flag_n = 1'b1;
                        state_nxt = SWC_ENTER;
                    end
                end
            end
            SWC_ENTER: begin
                // (R18) instruction completes first, (R15) then wakes at once
                if (irq_wake) begin
                    state_nxt = wake_state(xtal_mode);
                end else begin
                    state_nxt = SWC_SLEEP;
                end
            end
            SWC_SLEEP: begin
                if (wdog_expire) begin
                    // (R9) watchdog wake clears timeout flag
                    flags_nxt.timeout_flag_n = 1'b0;
                    state_nxt = wake_state(xtal_mode);
                end else if (irq_wake) begin
                    state_nxt = wake_state(xtal_mode);
                end
            end
            SWC_OST: begin
                // (R21) start-up delay
                if (ost_cnt_r == 11'(OST_CYCLES - 1)) begin
                    state_nxt = SWC_RESUME;
                end
            end
            SWC_RESUME: state_nxt = SWC_RUN;
            default: state_nxt = SWC_RUN;
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_r <= SWC_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // (R24) flags change at one clock edge; status writes ignored
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            // (R9) power-up sets powerdown flag
            flags_r <= '{timeout_flag_n: 1'b1, powerdown_flag_n: 1'b1};
        end else begin
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ost_cnt_r <= 11'h000;
        end else if (state_r == SWC_OST) begin
            ost_cnt_r <= ost_cnt_r + 11'h001;
        end else begin
            ost_cnt_r <= 11'h000;
        end
    end

    // (R2) cleared on sleep entry
    wire wdog_entry_clr = (state_nxt == SWC_ENTER);
    // (R16) cleared on every wake out of the sleep state
    wire wdog_wake_clr = (state_r == SWC_SLEEP) & (state_nxt != SWC_SLEEP);
    // (R23) held cleared while the start-up timer runs
    wire wdog_ost_hold = (state_r == SWC_OST);
    wire wdog_clear = watchdog_clear_instr_req | ~wdog_on | wdog_entry_clr | wdog_wake_clr |
                      wdog_ost_hold | wdog_expire;
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wdog_cnt_r <= '0;
        end else if (wdog_clear) begin
            wdog_cnt_r <= '0;
        end else begin
            wdog_cnt_r <= wdog_cnt_r + WDOG_W'(1);
        end
    end

    // watchdog control, unused upper bits read zero
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wdog_ctrl_r <= WDOG_CTRL_RST;
        end else if (wr_wdog) begin
            wdog_ctrl_r <= wd8 & WDOG_CTRL_MASK;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            options_r <= OPTIONS_RST;
        end else if (wr_opt) begin
            options_r <= wd8;
        end
    end

    // sleep control; pulse bits 7:6 are never stored
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            slp_ctrl_r <= 8'h00;
        end else if (wr_slp) begin
            slp_ctrl_r <= {2'h0, wd8[5:0]};
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            irq_en_r <= 8'h00;
        end else if (wr_ien) begin
            irq_en_r <= wd8;
        end
    end

    // irq flags: hardware set wins over a software clear
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            irq_flag_r <= 8'h00;
        end else begin
            irq_flag_r <= (wr_ifl ? (irq_flag_r & wd8) : irq_flag_r) | IRQ_FLAG_I;
        end
    end

    // config word keeps its reset value; writes leave it unchanged
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            config_r <= CONFIG_RST;
        end else if (wr_pend_r & (wr_idx_r == DEVICE_CONFIG_WORD_IDX) & ~in_sleep) begin
            config_r <= config_r;
        end
    end

    // ahb-lite data phase
    wire [7:0] status_rd = {3'h0, flags_r.timeout_flag_n, flags_r.powerdown_flag_n, 3'h0};
    wire [7:0] rd_mux =
        (acc_idx == CORE_STATUS_IDX) ? status_rd :
        (acc_idx == WATCHDOG_CONTROL_IDX) ? wdog_ctrl_r :
        (acc_idx == TIMER_PRESCALE_OPTIONS_IDX) ? options_r :
        (acc_idx == DEVICE_CONFIG_WORD_IDX) ? config_r :
        (acc_idx == SLEEP_CTRL_IDX) ? slp_ctrl_r :
        (acc_idx == IRQ_ENABLE_IDX) ? irq_en_r :
        (acc_idx == IRQ_FLAG_IDX) ? irq_flag_r :
        (acc_idx == SLEEP_STATE_IDX) ? {5'h00, state_r} : 8'h00;

    // write address held for the data phase
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wr_pend_r <= 1'b0;
        end else begin
            wr_pend_r <= bus_wr;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wr_idx_r <= 16'h0000;
        end else begin
            wr_idx_r <= acc_idx;
        end
    end

    // read data stands until the next read
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            hrdata_r <= 32'h0000_0000;
        end else if (bus_rd) begin
            hrdata_r <= {24'h000000, rd_mux};
        end
    end

    // (R5) pins frozen while oscillator is off
    wire pins_frozen = (state_r == SWC_SLEEP) | (state_r == SWC_OST) | (state_r == SWC_ENTER);
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pin_out_r <= 8'h00;
        end else if (!pins_frozen) begin
            pin_out_r <= PIN_OUT_I;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pin_oe_r <= 8'h00;
        end else if (!pins_frozen) begin
            pin_oe_r <= PIN_OE_I;
        end
    end

    // (R4) oscillator driver off in sleep
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            osc_en_r <= 1'b1;
        end else begin
            osc_en_r <= (state_nxt != SWC_SLEEP);
        end
    end

    // core runs only in the run state
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            core_run_r <= 1'b1;
        end else begin
            core_run_r <= (state_nxt == SWC_RUN);
        end
    end

    // (R12) prefetch next address during the instruction
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            prefetch_r <= 1'b0;
        end else begin
            prefetch_r <= (state_r == SWC_RUN) & sleep_req;
        end
    end

    // (R14) vector only with global enable after interrupt wake
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            vector_r <= 1'b0;
        end else begin
            vector_r <= (state_r == SWC_RESUME) & flags_r.timeout_flag_n &
                        slp_ctrl_r[SLP_GIE_BIT] & irq_pend;
        end
    end

    // (R8) watchdog wake resumes; running timeout resets core
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wdog_rst_r <= 1'b0;
        end else begin
            wdog_rst_r <= wdog_expire & (state_r == SWC_RUN);
        end
    end

    assign HRDATA_O = hrdata_r;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
    assign OSC_EN_O = osc_en_r;
    assign CORE_RUN_O = core_run_r;
    assign PREFETCH_O = prefetch_r;
    assign VECTOR_JUMP_O = vector_r;
    assign WDOG_RESET_O = wdog_rst_r;
    // (R7) master clear pin never driven by watchdog reset
    assign MASTER_CLEAR_OE_O = 1'b0;
    assign PIN_OUT_O = pin_out_r;
    assign PIN_OE_O = pin_oe_r;
endmodule

// file: dv/swc_props.sv
// port checker for the sleep/wake controller
module swc_props
    import swc_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RSTN_I,
    input wire logic OSC_EN_O,
    input wire logic CORE_RUN_O,
    input wire logic PREFETCH_O,
    input wire logic VECTOR_JUMP_O,
    input wire logic WDOG_RESET_O,
    input wire logic MASTER_CLEAR_OE_O,
    input wire logic [7:0] PIN_OUT_O,
    input wire logic [7:0] PIN_OE_O
);
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RSTN_I);
    // cycles spent with oscillator on but core still held
    logic [11:0] ost_seen_r;
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ost_seen_r <= 12'h000;
        end else if (!OSC_EN_O || CORE_RUN_O) begin
            ost_seen_r <= 12'h000;
        end else if (ost_seen_r != 12'hfff) begin
            ost_seen_r <= ost_seen_r + 12'h001;
        end
    end
    property p_entry; $fell(CORE_RUN_O) |-> PREFETCH_O; endproperty
    property p_pf; PREFETCH_O |=> !PREFETCH_O; endproperty
    property p_osc; !OSC_EN_O |-> !CORE_RUN_O; endproperty
    property p_pins; !OSC_EN_O |-> $stable(PIN_OUT_O) && $stable(PIN_OE_O); endproperty
    property p_ost;
        $rose(CORE_RUN_O) |-> (ost_seen_r >= 12'(OST_CYCLES)) && (ost_seen_r <= 12'(OST_CYCLES + 4));
    endproperty
    property p_master_clear_pin; WDOG_RESET_O |-> !MASTER_CLEAR_OE_O; endproperty
    property p_wdog; WDOG_RESET_O |-> CORE_RUN_O; endproperty
    property p_vec; VECTOR_JUMP_O |=> !VECTOR_JUMP_O; endproperty
    a_entry: assert property (p_entry) else $error("stop without prefetch");
    a_pf: assert property (p_pf) else $error("prefetch not a pulse");
    a_osc: assert property (p_osc) else $error("core runs with osc off");
    a_pins: assert property (p_pins) else $error("pins moved asleep");
    a_ost: assert property (p_ost) else $error("start-up delay wrong");
    a_master_clear_pin: assert property (p_master_clear_pin) else $error("master clear driven");
    a_wdog: assert property (p_wdog) else $error("wdog reset asleep");
    a_vec: assert property (p_vec) else $error("vector not a pulse");
    c_sleep: cover property ($fell(CORE_RUN_O));
    c_wake: cover property ($rose(CORE_RUN_O));
    c_vec: cover property (VECTOR_JUMP_O);
    c_wdog: cover property (WDOG_RESET_O);
endmodule

bind swc_sleep_wake swc_props i_swc_props (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I),
    .OSC_EN_O(OSC_EN_O), .CORE_RUN_O(CORE_RUN_O), .PREFETCH_O(PREFETCH_O),
    .VECTOR_JUMP_O(VECTOR_JUMP_O), .WDOG_RESET_O(WDOG_RESET_O),
    .MASTER_CLEAR_OE_O(MASTER_CLEAR_OE_O), .PIN_OUT_O(PIN_OUT_O), .PIN_OE_O(PIN_OE_O));

// file: dv/swc_core.sv
// core and interrupt source model for the controller's core side
module swc_core (
    input wire logic clk_i,
    output logic sleep_o,
    output logic watchdog_clear_instr_o,
    output logic [7:0] irq_o,
    output logic [7:0] pin_out_o,
    output logic [7:0] pin_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r = 8'h00;
    initial begin
        sleep_o = 1'b0;
        watchdog_clear_instr_o = 1'b0;
        irq_o = 8'h00;
    end
    // pins move every cycle so a held drive shows
    always @(posedge clk_i) cnt_r <= cnt_r + 8'h01;
    assign pin_out_o = cnt_r;
    assign pin_oe_o = ~cnt_r;
    task automatic pulse_sleep();
        sleep_o <= 1'b1;
        @(posedge clk_i);
        sleep_o <= 1'b0;
    endtask
    task automatic pulse_watchdog_clear_instr();
        watchdog_clear_instr_o <= 1'b1;
        @(posedge clk_i);
        watchdog_clear_instr_o <= 1'b0;
    endtask
    task automatic pulse_irq(input int i);
        irq_o[i] <= 1'b1;
        @(posedge clk_i);
        irq_o[i] <= 1'b0;
    endtask
endmodule

// file: dv/swc_sleep_wake_test.sv
// self-checking bench for the sleep/wake controller
module swc_sleep_wake_test;
    import swc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic [2:0] hsize = 3'b000;
    logic hready, osc, run, vec, wdr, master_clear_pin, slp, clr, hresp, pf;
    logic [7:0] irq, po, pe, pio, pie;
    int failures = 0;
    int num_checks = 0;
    swc_core i_swc_core (.clk_i(clk), .sleep_o(slp), .watchdog_clear_instr_o(clr), .irq_o(irq),
        .pin_out_o(po), .pin_oe_o(pe));
    swc_sleep_wake i_swc_sleep_wake (.REF_CLK_I(clk), .RSTN_I(rst_n), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
        .HWDATA_I(hwdata), .HREADY_I(hready), .SLEEP_INSTR_I(slp), .WATCHDOG_CLEAR_INSTR_INSTR_I(clr),
        .IRQ_FLAG_I(irq), .PIN_OUT_I(po), .PIN_OE_I(pe), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .OSC_EN_O(osc), .CORE_RUN_O(run),
        .PREFETCH_O(pf), .VECTOR_JUMP_O(vec), .WDOG_RESET_O(wdr),
        .MASTER_CLEAR_OE_O(master_clear_pin), .PIN_OUT_O(pio), .PIN_OE_O(pie));
    initial forever #2.5 clk = ~clk;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait for a core level; counts vector pulses
    task automatic wait_run(input logic lvl, input int lim, output int v);
        int n = 0;
        int left = 4;
        v = 0;
        while (left > 0) begin
            @(posedge clk);
            v += int'(vec === 1'b1);
            if (run === lvl || wdr === lvl) left--;
            if (++n > lim) begin
                failures++;
                print_verdict();
            end
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] ix, input logic [31:0] d,
                       output logic [31:0] r);
        int v;
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        haddr <= {14'h0, ix, 2'b00};
        wait_ready(v);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready(v);
        r = hrdata;
    endtask
    task automatic wait_ready(output int n);
        n = 0;
        do begin
            @(posedge clk);
            if (++n > 50) begin
                failures++;
                print_verdict();
            end
        end while (hready !== 1'b1);
    endtask
    task automatic wr(input logic [15:0] ix, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, ix, d, r);
    endtask
    task automatic rd(input string what, input logic [15:0] ix, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, ix, 32'h0, r);
        chk(what, e, r);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    initial begin
        logic [15:0] ix_t [5];
        logic [7:0] rv_t [5];
        int v;
        logic [15:0] pv;
        ix_t = '{CORE_STATUS_IDX, WATCHDOG_CONTROL_IDX, TIMER_PRESCALE_OPTIONS_IDX,
                 DEVICE_CONFIG_WORD_IDX, 16'h0200};
        rv_t = '{STATUS_RST, WDOG_CTRL_RST, OPTIONS_RST, CONFIG_RST, 8'h00};
        do_reset();
        for (int i = 0; i < 5; i++) rd("reset value", ix_t[i], {24'h0, rv_t[i]});
        wr(DEVICE_CONFIG_WORD_IDX, 32'hff);
        wr(CORE_STATUS_IDX, 32'h00);
        wr(WATCHDOG_CONTROL_IDX, 32'hfe);
        rd("config", DEVICE_CONFIG_WORD_IDX, 32'h0);
        rd("status", CORE_STATUS_IDX, 32'h18);
        rd("wdog ctrl", WATCHDOG_CONTROL_IDX, 32'h1e);
        $display("registers done");
        for (int g = 0; g < 2; g++) begin
            wr(IRQ_ENABLE_IDX, 32'h01);
            wr(SLEEP_CTRL_IDX, 32'(g));
            i_swc_core.pulse_sleep();
            @(negedge clk);
            chk("prefetch", 32'h1, {31'h0, pf});
            repeat (3) @(posedge clk);
            pv = {pie, pio};
            rd("status asleep", CORE_STATUS_IDX, 32'h10);
            chk("pins held", {16'h0, pv}, {16'h0, pie, pio});
            chk("hresp", 32'h0, {31'h0, hresp});
            chk("osc", 32'h0, {31'h0, osc});
            i_swc_core.pulse_irq(0);
            wait_run(1'b1, 1200, v);
            chk("vector", 32'(g), 32'(v));
            rd("status woken", CORE_STATUS_IDX, 32'h10);
            wr(IRQ_FLAG_IDX, 32'h0);
        end
        $display("interrupt wake done");
        do_reset();
        wr(IRQ_ENABLE_IDX, 32'h0c);
        wr(SLEEP_CTRL_IDX, 32'h02);
        i_swc_core.pulse_irq(3);
        i_swc_core.pulse_sleep();
        repeat (4) @(posedge clk);
        chk("nop run", 32'h1, {31'h0, run});
        rd("status nop", CORE_STATUS_IDX, 32'h18);
        wr(IRQ_FLAG_IDX, 32'h0);
        wr(SLEEP_CTRL_IDX, 32'h01);
        i_swc_core.pulse_sleep();
        i_swc_core.pulse_irq(3);
        repeat (20) @(posedge clk);
        chk("no wake", 32'h0, {31'h0, run});
        wr(SLEEP_CTRL_IDX, 32'h02);
        wait_run(1'b1, 1200, v);
        $display("enables done");
        for (int i = 0; i < NUM_IRQ; i++) begin
            wr(IRQ_FLAG_IDX, 32'h0);
            wr(IRQ_ENABLE_IDX, 32'h04 | (32'h1 << i));
            i_swc_core.pulse_sleep();
            i_swc_core.pulse_irq(2);
            repeat (20) @(posedge clk);
            chk("clocked source", 32'h0, {31'h0, run});
            i_swc_core.pulse_irq(i);
            if (SLEEP_CAPABLE[i]) wait_run(1'b1, 1200, v);
        end
        $display("sources done");
        do_reset();
        wr(WATCHDOG_CONTROL_IDX, 32'h01);
        for (int n = 0; n < 100 && wdr !== 1'b1; n++) @(posedge clk);
        chk("wdog reset", 32'h1, {31'h0, wdr});
        chk("master clear", 32'h0, {31'h0, master_clear_pin});
        i_swc_core.pulse_watchdog_clear_instr();
        i_swc_core.pulse_sleep();
        repeat (4) @(posedge clk);
        wait_run(1'b1, 1200, v);
        rd("status wdog wake", CORE_STATUS_IDX, 32'h00);
        $display("watchdog done");
        print_verdict();
    end
endmodule
